// file: hw/rsc_core.sv
`default_nettype none
// executes push, pop, relative call and software reset per quarter phase
module rsc_core
    import rsc_pkg::*;
#(
    parameter int AW    = 21,
    parameter int DEPTH = 31
) (
    // clock and reset
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_b,
    // instruction from decoder
    input  wire logic          i_instr_valid,
    input  wire logic [15:0]   i_instr,
    // program counter
    input  wire logic          i_pc_load,
    input  wire logic [AW-1:0] i_pc_value,
    output logic      [AW-1:0] o_pc,
    // status
    output logic      [1:0]    o_qphase,
    output logic      [AW-1:0] o_stack_top_entry,
    output logic               o_busy,
    output logic               o_master_clear_reset,
    output logic               o_flags_hold
);
    //----------------------------------------------------------------
    // parameter checks
    //----------------------------------------------------------------
    // the scaled offset is sign extended into the counter, so it must fit
    if (AW < 12) begin : g_bad_aw
        $error("rsc_core AW too small for offset");
    end
    if (DEPTH < 2) begin : g_bad_depth
        $error("rsc_core DEPTH too small");
    end

    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------

    typedef struct packed {
        rsc_state_type st;
        logic [1:0]    q;
        logic [15:0]   ir;
        logic [AW-1:0] pc;
        logic          rst;
    } rsc_core_type;

    rsc_core_type r_reg;
    rsc_core_type r_next;

    logic          push_now;
    logic          pop_now;
    logic [AW-1:0] ret_addr;
    logic [AW-1:0] call_tgt;
    logic [AW-1:0] top;

    //----------------------------------------------------------------
    // decode helpers
    //----------------------------------------------------------------
    function automatic logic is_call(input logic [15:0] w);
        return w[15:11] == RSC_CALL_HI;
    endfunction

    function automatic logic [AW-1:0] word_ofs(input logic [15:0] w);
        logic [AW-1:0] ext;
        ext = AW'($signed(w[RSC_OFS_W-1:0]));
        return {ext[AW-2:0], 1'b0};
    endfunction

    // return address and branch target
    assign ret_addr = r_reg.pc + AW'(RSC_PC_STEP);
    assign call_tgt = ret_addr + word_ofs(r_reg.ir);

    // stack writes happen in Q2, pop in Q3
    assign push_now = (r_reg.st == RSC_ST_FETCH) && (r_reg.q == RSC_Q2)
                      && ((r_reg.ir == RSC_OP_PUSH) || is_call(r_reg.ir));
    assign pop_now  = (r_reg.st == RSC_ST_FETCH) && (r_reg.q == RSC_Q3)
                      && (r_reg.ir == RSC_OP_POP);

    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        r_next     = r_reg;
        r_next.q   = r_reg.q + 2'h1;
        r_next.rst = 1'b0;
        case (r_reg.st)
            RSC_ST_FETCH: begin
                if (r_reg.q == RSC_Q1) begin
                    r_next.ir = i_instr_valid ? i_instr : 16'h0000;
                end
                if (r_reg.q == RSC_Q2 && r_reg.ir == RSC_OP_RESET) begin
                    r_next.rst = 1'b1;
                end
                if (r_reg.q == RSC_Q4) begin
                    if (is_call(r_reg.ir)) begin
                        r_next.pc = call_tgt;
                        r_next.st = RSC_ST_CALL_NOP;
                    end else if (i_pc_load) begin
                        r_next.pc = i_pc_value;
                    end else begin
                        r_next.pc = ret_addr;
                    end
                end
            end
            RSC_ST_CALL_NOP: begin
                if (r_reg.q == RSC_Q4) begin
                    r_next.st = RSC_ST_FETCH;
                    r_next.ir = 16'h0000;
                end
            end
            default: r_next.st = RSC_ST_FETCH;
        endcase
    end

    //----------------------------------------------------------------
    // state register
    //----------------------------------------------------------------
    // software reset returns all to reset values one clock after Q2
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r_reg <= '0;
        end else if (r_reg.rst) begin
            r_reg <= '{st: RSC_ST_FETCH, q: 2'h0, ir: 16'h0000, pc: '0, rst: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    //----------------------------------------------------------------
    // return stack
    //----------------------------------------------------------------
    // software reset empties the stack by a clocked clear, not by a
    // gated reset, so no glitch reaches the asynchronous reset pin
    rsc_stack #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_stack (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (r_reg.rst),
        .i_push    (push_now),
        .i_pop     (pop_now),
        .i_data    (ret_addr),
        .o_top     (top)
    );

    //----------------------------------------------------------------
    // outputs
    //----------------------------------------------------------------
    assign o_pc                 = r_reg.pc;
    assign o_qphase             = r_reg.q;
    assign o_stack_top_entry    = top;
    assign o_busy               = r_reg.st == RSC_ST_CALL_NOP;
    assign o_master_clear_reset = r_reg.rst;
    assign o_flags_hold         = ~r_reg.rst;

    //----------------------------------------------------------------
    // assertions
    //----------------------------------------------------------------
    a_push_top_value: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        push_now && !r_reg.rst |=> top == $past(r_reg.pc) + AW'(RSC_PC_STEP))
        else $error("push did not write pc plus two");
    a_push_shift_down: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        push_now && !r_reg.rst |=> u_stack.s_reg.ent[1] == $past(top))
        else $error("old top not moved down");
    // the stack top may only move at the end of Q2, Q3 or a software reset
    a_stack_write_phase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !$stable(top) |-> $past(r_reg.q) == RSC_Q2 || $past(r_reg.q) == RSC_Q3
        || $past(r_reg.rst))
        else $error("stack changed outside its phase");
    a_flags_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        r_reg.ir == RSC_OP_PUSH || is_call(r_reg.ir) |-> o_flags_hold)
        else $error("flags disturbed by push or call");
    a_pc_plain_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        r_reg.st == RSC_ST_FETCH && r_reg.q == RSC_Q4 && !is_call(r_reg.ir) && !i_pc_load
        |=> o_pc == $past(r_reg.pc) + AW'(RSC_PC_STEP))
        else $error("pc did not step by one word");
    a_call_decode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        r_reg.st == RSC_ST_FETCH && r_reg.q == RSC_Q2 && r_reg.ir[15:11] == RSC_CALL_HI
        |-> push_now)
        else $error("relative call not decoded");
    a_call_ret_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        push_now && is_call(r_reg.ir) |=> top == $past(r_reg.pc) + AW'(RSC_PC_STEP))
        else $error("call return address wrong");
    // target from twice the offset field, then four idle clocks, then fetch
    a_call_target: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        r_reg.st == RSC_ST_FETCH && r_reg.q == RSC_Q4 && is_call(r_reg.ir) && !r_reg.rst
        |=> o_pc == $past(r_reg.pc) + AW'(RSC_PC_STEP)
            + AW'($signed({$past(r_reg.ir[RSC_OFS_W-1:0]), 1'b0}))
        ##0 o_busy [*4] ##1 !o_busy)
        else $error("call target or nop cycle wrong");
    a_nop_ignores: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_busy && r_reg.q != RSC_Q4 |=> $stable(r_reg.ir) && $stable(top) && $stable(o_pc))
        else $error("instruction taken during the idle cycle");
    a_reset_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        r_reg.rst |=> o_pc == '0 && top == '0 && o_qphase == 2'h0 && !o_busy)
        else $error("software reset incomplete");
    a_pop_discards: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        pop_now && !r_reg.rst |=> top == $past(u_stack.s_reg.ent[1]))
        else $error("pop did not expose next entry");

    //----------------------------------------------------------------
    // cover points
    //----------------------------------------------------------------
    c_push: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        push_now && r_reg.ir == RSC_OP_PUSH);
    c_call: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_busy);
    c_call_back: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        push_now && is_call(r_reg.ir) && r_reg.ir[RSC_OFS_W-1]);
    c_pop: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) pop_now);
    c_reset: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) r_reg.rst);
endmodule
`default_nettype wire

// file: hw/rsc_pkg.sv
// Notes on behaviour
// - The push opcode 0x0005 writes the program counter plus two into the stack top entry.
// - On push, the old top value moves one level down the return stack, until the next push or pop moves it again.
// - Push is one word and one cycle, writes the stack in Q2 and leaves flags alone.
// - Relative call decodes from upper bits 11011 and an 11-bit signed word offset.
// - Relative call pushes the counter plus two as return address before branching.
// - Relative call jumps to the counter plus two plus twice the offset in two cycles.
// - The opcode 0x00FF returns every master clear reset register and flag to reset.
// - The pop opcode 0x0006 discards the top entry, so the entry below becomes the new top.
`default_nettype none
package rsc_pkg;
    //----------------------------------------------------------------
    // opcodes and quarter phases
    //----------------------------------------------------------------
    localparam logic [15:0] RSC_OP_PUSH  = 16'h0005;
    localparam logic [15:0] RSC_OP_POP   = 16'h0006;
    localparam logic [15:0] RSC_OP_RESET = 16'h00FF;
    localparam logic [4:0]  RSC_CALL_HI  = 5'h1B;
    localparam int          RSC_OFS_W    = 11;
    localparam logic [1:0]  RSC_Q1       = 2'h0;
    localparam logic [1:0]  RSC_Q2       = 2'h1;
    localparam logic [1:0]  RSC_Q3       = 2'h2;
    localparam logic [1:0]  RSC_Q4       = 2'h3;
    localparam int          RSC_PC_STEP  = 2;

    typedef enum logic [1:0] {RSC_ST_FETCH, RSC_ST_CALL_NOP} rsc_state_type;
endpackage
`default_nettype wire

// file: hw/rsc_stack.sv
`default_nettype none
// return stack storage, one push or pop at a time
module rsc_stack
    import rsc_pkg::*;
#(
    parameter int DEPTH = 31,
    parameter int AW    = 21
) (
    // clock and reset
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_b,
    // operations
    input  wire logic          i_push,
    input  wire logic          i_pop,
    input  wire logic          i_clear,
    input  wire logic [AW-1:0] i_data,
    // top of stack
    output logic      [AW-1:0] o_top
);
    // refuse sizes the shift logic cannot serve
    if (DEPTH < 2 || AW < 2) begin : g_bad_param
        $error("rsc_stack bad parameters");
    end

    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] ent;
    } rsc_stk_type;

    rsc_stk_type s_reg;
    rsc_stk_type s_next;

    //----------------------------------------------------------------
    // shift register stack
    //----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (i_clear) begin
            s_next = '0;
        end else if (i_push) begin
            s_next.ent[0] = i_data;
            for (int i = 1; i < DEPTH; i++) begin
                s_next.ent[i] = s_reg.ent[i-1];
            end
        end else if (i_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_next.ent[i] = s_reg.ent[i+1];
            end
            s_next.ent[DEPTH-1] = '0;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_top = s_reg.ent[0];
endmodule
`default_nettype wire

// file: sim/return_stack_call_instructions_tb.sv
`default_nettype none
module return_stack_call_instructions_tb
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    //----------------------------------------------------------------
    // stimulus and observed signals
    //----------------------------------------------------------------
    logic        i_sys_clk;
    logic        i_rst_b;
    logic        i_instr_valid;
    logic [15:0] i_instr;
    logic        i_pc_load;
    logic [20:0] i_pc_value;
    logic [20:0] o_pc;
    logic [1:0]  o_qphase;
    logic [20:0] o_stack_top_entry;
    logic        o_busy;
    logic        o_master_clear_reset;
    logic        o_flags_hold;
    int          err_total;
    int          checks_done;
    int          cycles;

    rsc_core #(.AW(21), .DEPTH(31)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .o_pc(o_pc),
        .o_qphase(o_qphase), .o_stack_top_entry(o_stack_top_entry), .o_busy(o_busy),
        .o_master_clear_reset(o_master_clear_reset), .o_flags_hold(o_flags_hold));

    // 250 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    // hang guard
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            finish_test();
        end
    end

    //----------------------------------------------------------------
    // shared tasks
    //----------------------------------------------------------------
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // present one word at Q1, return at the negedge inside Q2
    task automatic issue(input logic [15:0] op);
        int n;
        n = 0;
        while (!(o_qphase === RSC_Q1 && o_busy === 1'b0) && n < 50) begin
            @(negedge i_sys_clk);
            n++;
        end
        i_instr = op;
        i_instr_valid = 1'b1;
        @(negedge i_sys_clk);
        i_instr_valid = 1'b0;
        i_instr = 16'h0000;
    endtask

    //----------------------------------------------------------------
    // scenarios
    //----------------------------------------------------------------
    task automatic run_push();
        logic [20:0] p0, t0;
        p0 = o_pc;
        t0 = o_stack_top_entry;
        issue(RSC_OP_PUSH);
        chk(o_stack_top_entry, t0);
        @(negedge i_sys_clk);
        chk(o_stack_top_entry, p0 + 21'h2);
        repeat (2) @(negedge i_sys_clk);
        chk(o_pc, p0 + 21'h2);
        chk(21'(o_flags_hold), 21'h1);
    endtask

    task automatic push_pop();
        logic [20:0] a;
        run_push();
        a = o_stack_top_entry;
        run_push();
        issue(RSC_OP_POP);
        repeat (3) @(negedge i_sys_clk);
        chk(o_stack_top_entry, a);
    endtask

    task automatic load_pc(input logic [20:0] v);
        i_pc_load = 1'b1;
        i_pc_value = v;
        issue(16'h0000);
        repeat (3) @(negedge i_sys_clk);
        i_pc_load = 1'b0;
        chk(o_pc, v);
    endtask

    // call, with a refused push held up during the idle cycle
    task automatic rel_call(input logic [10:0] n);
        logic [20:0] ret, tgt;
        ret = o_pc + 21'h2;
        tgt = ret + {{9{n[10]}}, n, 1'b0};
        issue({RSC_CALL_HI, n});
        @(negedge i_sys_clk);
        chk(o_stack_top_entry, ret);
        repeat (2) @(negedge i_sys_clk);
        chk(o_pc, tgt);
        chk(21'(o_busy), 21'h1);
        i_instr = RSC_OP_PUSH;
        i_instr_valid = 1'b1;
        repeat (3) begin
            @(negedge i_sys_clk);
            chk(21'(o_busy), 21'h1);
        end
        i_instr_valid = 1'b0;
        @(negedge i_sys_clk);
        chk(21'(o_busy), 21'h0);
        chk(o_stack_top_entry, ret);
    endtask

    task automatic soft_reset();
        issue(RSC_OP_RESET);
        @(negedge i_sys_clk);
        chk(21'(o_master_clear_reset), 21'h1);
        chk(21'(o_flags_hold), 21'h0);
        @(negedge i_sys_clk);
        chk(o_pc, 21'h0);
        chk(o_stack_top_entry, 21'h0);
        chk(21'(o_master_clear_reset), 21'h0);
        chk(21'(o_qphase), 21'h0);
        chk(21'(o_busy), 21'h0);
        chk(21'(o_flags_hold), 21'h1);
    endtask

    //----------------------------------------------------------------
    // main sequence
    //----------------------------------------------------------------
    initial begin
        err_total = 0;
        checks_done = 0;
        cycles = 0;
        i_rst_b = 1'b0;
        i_instr_valid = 1'b0;
        i_instr = 16'h0000;
        i_pc_load = 1'b0;
        i_pc_value = 21'h0;
        repeat (16) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        push_pop();
        load_pc(21'h1ABCD);
        rel_call(11'h3FF);
        rel_call(11'h400);
        load_pc(21'h000010);
        rel_call(11'h7FF);
        soft_reset();
        finish_test();
    end
endmodule
`default_nettype wire
